// [rtl/vot_consts.svh]
// constants for the video output timing and genlock block
// assumes a single 125 MHz system clock standing in for the double-rate clock
//
// Operation
// - genlock serial output sends frequency word, then phase reset bit
// - frequency word is 23 bits, unsigned binary
// - oscillator frequency equals word over two to the 23, times double-rate clock
// - least significant bit of sent frequency word is always zero
// - writing one to bit 4 of chroma control sends reset next line
// - reset bit is active low, 7 double-rate cycles after last word bit
// - sending the reset bit clears the internal oscillator phase
// - pixel clock output suits 20-bit and 16-bit capture
// - double-rate clock output suits 10-bit, 8-bit and BT.656 capture
// - clock qualifier with double-rate clock marks 20/16-bit capture edges
// - support 20,16,10,8-bit 4:2:2 and 10,8-bit BT.656, both samplings
// - samples in 4:2:2 order, alternate samples carry chroma
// - 525-line BT.601: 858 total, 720 active pixels per line
// - 525-line square pixel: 780 total, 640 active pixels per line
// - 625-line BT.601: 864 total, 720 active pixels per line
// - 625-line square pixel: 944 total, 768 active pixels per line
// - active-video flag rises 4 double-rate cycles earlier in BT.656 mode
// - sync start register default 80h gives nominal sync, changes move it
`ifndef VOT_CONSTS_SVH
`define VOT_CONSTS_SVH
`define VOT_REG_SYNC_START   8'h16
`define VOT_REG_CHROMA_CTRL  8'h1a
`define VOT_REG_FREQ0        8'h1b
`define VOT_REG_FREQ1        8'h1c
`define VOT_REG_FREQ2        8'h1d
`define VOT_REG_FORMAT       8'h1e
`define VOT_REG_STATUS       8'h1f
`define VOT_RST_SYNC_START   8'h80
`define VOT_RST_CHROMA_CTRL  8'h00
`define VOT_RST_FREQ         23'h43_E0F8
`define VOT_RST_FORMAT       8'h00
`define VOT_BIT_PHASE_RST    4
`define VOT_FREQ_W           23
`define VOT_RST_GAP_CYC      7
`define VOT_ACTIVE_VIDEO_FLAG_EARLY_CYC   4
`define VOT_SYNC_LEN         12'h080
`define VOT_GENLOCK_SERIAL_OUT_START       12'h010
`define VOT_TOT_525_601      12'h35a
`define VOT_ACT_525_601      12'h2d0
`define VOT_TOT_525_SQP      12'h30c
`define VOT_ACT_525_SQP      12'h280
`define VOT_TOT_625_601      12'h360
`define VOT_ACT_625_601      12'h2d0
`define VOT_TOT_625_SQP      12'h3b0
`define VOT_ACT_625_SQP      12'h300
`define VOT_FIFO_DEPTH       8
`endif

// [rtl/vot_pkg.sv]
// types shared by the video output timing block
// assumes nothing beyond the constants header
package vot_pkg;
  typedef enum logic [2:0] {
    VOT_FMT_20 = 3'b000,
    VOT_FMT_16 = 3'b001,
    VOT_FMT_10 = 3'b010,
    VOT_FMT_8  = 3'b011,
    VOT_FMT_656_10 = 3'b100,
    VOT_FMT_656_8  = 3'b101
  } vot_fmt_e;
  typedef enum logic [1:0] {
    VOT_GL_IDLE = 2'b00,
    VOT_GL_WORD = 2'b01,
    VOT_GL_GAP  = 2'b10,
    VOT_GL_RST  = 2'b11
  } vot_gl_e;
endpackage

// [rtl/vot_fifo.sv]
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
module vot_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;
  logic [AW:0]      count_nxt;

  // empty from the occupancy count; ready is a flop fed by the next count
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem[rd_ptr_r];
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;

  // next occupancy, so ready leaves the block straight from a flop
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // storage has no reset, only pointers, count and ready do
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers and count
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r    <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r    <= count_nxt;
      o_in_ready <= (count_nxt != DEPTH[AW:0]);
    end
  end
endmodule // vot_fifo

// [rtl/vot_glock.sv]
// genlock serial sender: frequency word then active-low phase reset bit
// assumes a start pulse once per line from the timing logic
`timescale 1ns/1ns
`include "vot_consts.svh"
module vot_glock (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // control
  input  wire logic        i_line_start,
  input  wire logic [22:0] i_freq_word,
  input  wire logic        i_rst_req,
  // results
  output logic             o_serial,
  output logic             o_rst_sent,
  output logic             o_busy
);
  vot_pkg::vot_gl_e state_r;
  logic [22:0]      shift_r;
  logic [4:0]       cnt_r;
  logic             send_rst_r;

  assign o_busy = (state_r != vot_pkg::VOT_GL_IDLE);

  // frame sequencer; reset request is latched at line start only
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r    <= vot_pkg::VOT_GL_IDLE;
      shift_r    <= '0;
      cnt_r      <= '0;
      send_rst_r <= 1'b0;
      o_serial   <= 1'b1;
      o_rst_sent <= 1'b0;
    end else begin
      o_rst_sent <= 1'b0;
      case (state_r)
        vot_pkg::VOT_GL_IDLE: begin
          o_serial <= 1'b1;
          if (i_line_start) begin
            // word is 23-bit unsigned, msb first, bit 0 forced low
            shift_r    <= {i_freq_word[22:1], 1'b0};
            send_rst_r <= i_rst_req;
            cnt_r      <= 5'(`VOT_FREQ_W - 1);
            state_r    <= vot_pkg::VOT_GL_WORD;
          end
        end
        vot_pkg::VOT_GL_WORD: begin
          o_serial <= shift_r[22];
          shift_r  <= {shift_r[21:0], 1'b0};
          if (cnt_r == '0) begin
            cnt_r   <= 5'(`VOT_RST_GAP_CYC - 1);
            state_r <= send_rst_r ? vot_pkg::VOT_GL_GAP
                                  : vot_pkg::VOT_GL_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        vot_pkg::VOT_GL_GAP: begin
          o_serial <= 1'b1;
          if (cnt_r == '0) begin
            state_r <= vot_pkg::VOT_GL_RST;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        vot_pkg::VOT_GL_RST: begin
          // idle level is high, so the reset bit shows as a low
          o_serial   <= 1'b0;
          o_rst_sent <= 1'b1;
          send_rst_r <= 1'b0;
          state_r    <= vot_pkg::VOT_GL_IDLE;
        end
        default: state_r <= vot_pkg::VOT_GL_IDLE;
      endcase
    end
  end
endmodule // vot_glock

// [rtl/vot_top.sv]
// video output timing, 4:2:2 formatter and genlock control
// assumes i_clk_sys is the double-rate sample clock; host pokes registers
`timescale 1ns/1ns
`include "vot_consts.svh"
module vot_top (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // host register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  // decoded pixel input, one luma and one chroma per pixel
  input  wire logic        i_pix_valid,
  input  wire logic [9:0]  i_pix_y,
  input  wire logic [9:0]  i_pix_c,
  output logic             o_pix_ready,
  // video port
  output logic [9:0]       o_y_data,
  output logic [9:0]       o_uv_data,
  output logic             o_pclk,
  output logic             o_sclk_en,
  output logic             o_capture_qualifier,
  output logic             o_line_sync_out,
  output logic             o_active_video_flag,
  // genlock
  output logic             o_genlock_serial_out
);
  // registers
  logic [7:0]  sync_start_r;
  logic [7:0]  chroma_ctrl_r;
  logic [22:0] freq_r;
  logic [7:0]  format_r;
  logic        rst_req_r;
  // timing
  logic [11:0] hcnt_r;
  logic        phase_r;
  logic [11:0] tot_pix;
  logic [11:0] act_pix;
  logic [2:0]  fmt;
  logic        is_656;
  logic        line_start;
  // oscillator
  logic [22:0] phase_acc_r;
  logic        gl_serial;
  logic        gl_rst_sent;
  logic        gl_busy;
  // fifo
  logic        f_valid;
  logic [19:0] f_data;
  logic        f_pop;
  logic        chroma_sel_r;
  logic [9:0]  y_hold_r;
  logic [9:0]  c_hold_r;
  logic        act_r;

  assign fmt    = format_r[2:0];
  assign is_656 = (fmt == 3'(vot_pkg::VOT_FMT_656_10)) ||
                  (fmt == 3'(vot_pkg::VOT_FMT_656_8));

  // line length and active width, square vs 601, 525 vs 625
  always_comb begin
    case (format_r[5:4])
      2'b00: begin
        tot_pix = `VOT_TOT_525_601;
        act_pix = `VOT_ACT_525_601;
      end
      2'b01: begin
        tot_pix = `VOT_TOT_525_SQP;
        act_pix = `VOT_ACT_525_SQP;
      end
      2'b10: begin
        tot_pix = `VOT_TOT_625_601;
        act_pix = `VOT_ACT_625_601;
      end
      default: begin
        tot_pix = `VOT_TOT_625_SQP;
        act_pix = `VOT_ACT_625_SQP;
      end
    endcase
  end

  // host writes; the phase reset bit self-clears once armed
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_start_r  <= `VOT_RST_SYNC_START;
      chroma_ctrl_r <= `VOT_RST_CHROMA_CTRL;
      freq_r        <= `VOT_RST_FREQ;
      format_r      <= `VOT_RST_FORMAT;
      rst_req_r     <= 1'b0;
    end else begin
      // a new request wins over the line-start consume
      if (i_reg_wr && i_reg_addr == `VOT_REG_CHROMA_CTRL &&
          i_reg_wdata[`VOT_BIT_PHASE_RST]) begin
        rst_req_r <= 1'b1;
      end else if (line_start) begin
        rst_req_r <= 1'b0;
      end
      if (i_reg_wr) begin
        case (i_reg_addr)
          `VOT_REG_SYNC_START:  sync_start_r <= i_reg_wdata;
          `VOT_REG_CHROMA_CTRL: chroma_ctrl_r <= i_reg_wdata &
                                  ~(8'h01 << `VOT_BIT_PHASE_RST);
          `VOT_REG_FREQ0:       freq_r[7:0] <= i_reg_wdata;
          `VOT_REG_FREQ1:       freq_r[15:8] <= i_reg_wdata;
          `VOT_REG_FREQ2:       freq_r[22:16] <= i_reg_wdata[6:0];
          `VOT_REG_FORMAT:      format_r <= i_reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `VOT_REG_SYNC_START:  o_reg_rdata <= sync_start_r;
        `VOT_REG_CHROMA_CTRL: o_reg_rdata <= chroma_ctrl_r |
                                {3'b000, rst_req_r, 4'h0};
        `VOT_REG_FREQ0:       o_reg_rdata <= freq_r[7:0];
        `VOT_REG_FREQ1:       o_reg_rdata <= freq_r[15:8];
        `VOT_REG_FREQ2:       o_reg_rdata <= {1'b0, freq_r[22:16]};
        `VOT_REG_FORMAT:      o_reg_rdata <= format_r;
        `VOT_REG_STATUS:      o_reg_rdata <= {5'h00, gl_busy,
                                act_r, o_line_sync_out};
        default:              o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // pixel phase and horizontal counter on the double-rate clock
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_r <= 1'b0;
      hcnt_r  <= '0;
    end else begin
      phase_r <= ~phase_r;
      if (phase_r) begin
        hcnt_r <= (hcnt_r >= tot_pix - 12'd1) ? '0 : hcnt_r + 12'd1;
      end
    end
  end

  assign line_start = phase_r && (hcnt_r == `VOT_GENLOCK_SERIAL_OUT_START);

  // pixel clock at half rate, qualifier marks its capture edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pclk              <= 1'b0;
      o_sclk_en           <= 1'b0;
      o_capture_qualifier <= 1'b0;
    end else begin
      o_pclk              <= ~phase_r;
      o_sclk_en           <= 1'b1;
      o_capture_qualifier <= phase_r;
    end
  end

  // sync start shifts the pulse relative to its 80h nominal spot
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line_sync_out <= 1'b1;
    end else begin
      o_line_sync_out <= !((hcnt_r >= act_pix + {4'h0, sync_start_r}) &&
        (hcnt_r < act_pix + {4'h0, sync_start_r} + `VOT_SYNC_LEN));
    end
  end

  // active flag; in BT.656 it rises two pixels (4 sclk) early
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_r               <= 1'b0;
      o_active_video_flag <= 1'b0;
    end else begin
      act_r <= (hcnt_r < act_pix);
      o_active_video_flag <= (hcnt_r < act_pix) ||
        (is_656 && hcnt_r >= tot_pix - 12'(`VOT_ACTIVE_VIDEO_FLAG_EARLY_CYC / 2));
    end
  end

  // oscillator phase accumulator, cleared when reset bit goes out
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_acc_r <= '0;
    end else if (gl_rst_sent) begin
      phase_acc_r <= '0;
    end else begin
      phase_acc_r <= phase_acc_r + {freq_r[22:1], 1'b0};
    end
  end

  vot_glock u_glock (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_line_start (line_start),
    .i_freq_word  (freq_r),
    .i_rst_req    (rst_req_r),
    .o_serial     (gl_serial),
    .o_rst_sent   (gl_rst_sent),
    .o_busy       (gl_busy)
  );

  // serial pin comes out of a flop here too
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_genlock_serial_out <= 1'b1;
    end else begin
      o_genlock_serial_out <= gl_serial;
    end
  end

  // pixels drain one per pixel period during active video only,
  // so outside the active window the fifo stalls the source once it holds eight
  assign f_pop = f_valid && phase_r && (hcnt_r < act_pix);

  vot_fifo #(.WIDTH(20), .DEPTH(`VOT_FIFO_DEPTH)) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_pix_valid),
    .i_in_data   ({i_pix_y, i_pix_c}),
    .o_in_ready  (o_pix_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_pop)
  );

  // hold the popped pixel; chroma alternates Cb/Cr each pixel
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      y_hold_r     <= '0;
      c_hold_r     <= 10'h200;
      chroma_sel_r <= 1'b0;
    end else begin
      if (f_pop) begin
        y_hold_r     <= f_data[19:10];
        c_hold_r     <= f_data[9:0];
        chroma_sel_r <= ~chroma_sel_r;
      end
      if (line_start) begin
        chroma_sel_r <= 1'b0;
      end
    end
  end

  // output mux: wide formats hold Y and UV, narrow ones interleave
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_y_data  <= 10'h040;
      o_uv_data <= 10'h200;
    end else begin
      case (fmt)
        3'b000: begin
          o_y_data  <= y_hold_r;
          o_uv_data <= c_hold_r;
        end
        3'b001: begin
          o_y_data  <= {y_hold_r[9:2], 2'b00};
          o_uv_data <= {c_hold_r[9:2], 2'b00};
        end
        3'b010, 3'b100: begin
          o_y_data  <= phase_r ? y_hold_r : c_hold_r;
          o_uv_data <= 10'h000;
        end
        default: begin
          o_y_data  <= phase_r ? {y_hold_r[9:2], 2'b00}
                               : {c_hold_r[9:2], 2'b00};
          o_uv_data <= 10'h000;
        end
      endcase
    end
  end
endmodule // vot_top

// [bench/vot_top_checker.sv]
// checker: clock outputs and register port properties of vot_top
// assumes it is bound onto vot_top and sees only its ports
`timescale 1ns/1ns
`include "vot_consts.svh"
module vot_top_checker (
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  // register port
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // video port
  input wire logic       o_pclk,
  input wire logic       o_sclk_en,
  input wire logic       o_capture_qualifier,
  input wire logic       o_active_video_flag
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] sync_shadow_r;
  // shadow of the sync start register, so reads can be predicted
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      sync_shadow_r <= `VOT_RST_SYNC_START;
    else if (i_reg_wr && i_reg_addr == `VOT_REG_SYNC_START)
      sync_shadow_r <= i_reg_wdata;
  end
  // two running cycles, so $past never looks into reset
  sequence s_clk_running;
    o_sclk_en ##1 o_sclk_en;
  endsequence
  AST_PCLK_TOGGLE: assert property (
    s_clk_running |-> o_pclk != $past(o_pclk))
    else $error("pixel clock stopped toggling");
  AST_QUAL_RISE: assert property (
    $rose(o_capture_qualifier) |=> !o_capture_qualifier)
    else $error("qualifier high two cycles");
  AST_QUAL_FALL: assert property (
    s_clk_running ##0 $fell(o_capture_qualifier) |=> o_capture_qualifier)
    else $error("qualifier low two cycles");
  AST_SCLK_ON: assert property (
    !o_sclk_en |-> ##[1:2] o_sclk_en)
    else $error("double-rate clock not enabled");
  AST_SCLK_HOLD: assert property (
    o_sclk_en |=> o_sclk_en)
    else $error("double-rate clock dropped");
  AST_RD_SYNC: assert property (
    i_reg_rd && !i_reg_wr && i_reg_addr == `VOT_REG_SYNC_START
    |=> o_reg_rdata == $past(sync_shadow_r))
    else $error("sync start read wrong");
  AST_RD_UNMAPPED: assert property (
    i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");
  AST_ACTIVE_VIDEO_FLAG_MIN: assert property (
    $rose(o_active_video_flag) |-> o_active_video_flag [*8])
    else $error("active video pulse too short");
  AST_ACTIVE_VIDEO_FLAG_GAP: assert property (
    $fell(o_active_video_flag) |-> (!o_active_video_flag) [*8])
    else $error("blanking too short");
endmodule // vot_top_checker

bind vot_top vot_top_checker u_chk (
  .i_clk_sys, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .o_pclk, .o_sclk_en, .o_capture_qualifier,
  .o_active_video_flag
);

// [bench/vot_sink_model.sv]
// partner: video sink line meter and genlock slave decoder
// assumes the genlock line idles high and the word goes msb first
`timescale 1ns/1ns
module vot_sink_model (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // video port and genlock line
  input  wire logic        i_serial,
  input  wire logic        i_sync_n,
  input  wire logic        i_active_video_flag,
  // word the slave locks to
  input  wire logic [22:0] i_word,
  // decode counts and line measurements
  output int               o_words,
  output int               o_rsts,
  output int               o_tot,
  output int               o_act,
  output int               o_ofs
);
  logic [22:0] hist_r;
  logic        sync_q_r;
  logic        active_video_flag_q_r;
  int          gap_r;
  int          cyc_r;
  int          act_r;
  int          ofs_r;
  // slave decoder: idle high, then the word; no framing bit exists,
  // so a unique word pattern is the only way to find the frame
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_r  <= '1;
      gap_r   <= 0;
      o_words <= 0;
      o_rsts  <= 0;
    end else begin
      hist_r <= {hist_r[21:0], i_serial};
      if ({hist_r, i_serial} == {1'b1, i_word}) begin
        o_words <= o_words + 1;
        gap_r   <= 1;
      end else if (gap_r == 8 || (gap_r > 0 && !i_serial)) begin
        // reset bit counts only after exactly seven high cycles
        if (gap_r == 8 && !i_serial)
          o_rsts <= o_rsts + 1;
        gap_r <= 0;
      end else if (gap_r > 0)
        gap_r <= gap_r + 1;
    end
  end
  // line meter: counts in double-rate cycles between sync falls
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_q_r <= 1'b1;
      active_video_flag_q_r <= 1'b0;
      cyc_r    <= 0;
      act_r    <= 0;
      ofs_r    <= 0;
      o_tot    <= 0;
      o_act    <= 0;
      o_ofs    <= 0;
    end else begin
      sync_q_r <= i_sync_n;
      active_video_flag_q_r <= i_active_video_flag;
      cyc_r    <= cyc_r + 1;
      act_r    <= act_r + (i_active_video_flag ? 1 : 0);
      ofs_r    <= (active_video_flag_q_r && !i_active_video_flag) ? 1 : ofs_r + 1;
      if (sync_q_r && !i_sync_n) begin
        o_tot <= cyc_r;
        o_act <= act_r;
        o_ofs <= ofs_r;
        cyc_r <= 1;
        act_r <= i_active_video_flag ? 1 : 0;
      end
    end
  end
endmodule // vot_sink_model

// [bench/tb_video_output_timing_genlock.sv]
// testbench: registers, line timing, genlock frames, pixel buffer
// assumes vot_top on a 125 MHz clock with the sink model beside it
`timescale 1ns/1ns
module tb_video_output_timing_genlock;
  logic        i_clk_sys;
  logic        i_rst_n;
  logic        i_reg_wr;
  logic        i_reg_rd;
  logic [7:0]  i_reg_addr;
  logic [7:0]  i_reg_wdata;
  logic [7:0]  o_reg_rdata;
  logic        i_pix_valid;
  logic [9:0]  i_pix_y;
  logic [9:0]  i_pix_c;
  logic        o_pix_ready;
  logic [9:0]  o_y_data;
  logic [9:0]  o_uv_data;
  logic        o_line_sync_out;
  logic        o_active_video_flag;
  logic        o_genlock_serial_out;
  int          words, rsts, tot, act, ofs;
  int          err_count;
  int          n_checks;
  logic [11:0] tot_px [4] = '{12'h35a, 12'h30c, 12'h360, 12'h3b0};
  logic [11:0] act_px [4] = '{12'h2d0, 12'h280, 12'h2d0, 12'h300};

  vot_top u_dut (
    .i_clk_sys, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .i_pix_valid, .i_pix_y, .i_pix_c,
    .o_pix_ready, .o_y_data, .o_uv_data, .o_pclk(), .o_sclk_en(),
    .o_capture_qualifier(), .o_line_sync_out, .o_active_video_flag,
    .o_genlock_serial_out
  );
  vot_sink_model u_sink (
    .i_clk_sys, .i_rst_n, .i_serial(o_genlock_serial_out),
    .i_sync_n(o_line_sync_out), .i_active_video_flag(o_active_video_flag),
    .i_word(23'h2a_aaaa), .o_words(words), .o_rsts(rsts),
    .o_tot(tot), .o_act(act), .o_ofs(ofs)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clk_sys);
    i_reg_wr    <= 1'b0;
  endtask
  // read data is registered, so it is taken a half cycle after the edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk_sys);
    i_reg_rd   <= 1'b0;
    @(negedge i_clk_sys);
    d = o_reg_rdata;
  endtask
  // wait for n falls of sync (which 0) or active video (which 1)
  task automatic wait_fall(input bit which, input int n);
    int   k;
    logic p;
    logic v;
    k = 0;
    p = 1'b1;
    while (n > 0) begin
      @(negedge i_clk_sys);
      v = which ? !o_active_video_flag : !o_line_sync_out;
      if (v && !p)
        n--;
      p = v;
      k++;
      if (k > 8000) begin
        err_count++;
        conclude();
      end
    end
    // the sink latches its line figures one edge after it sees the fall
    @(negedge i_clk_sys);
  endtask

  initial begin
    logic [7:0] d;
    logic [9:0] y0;
    int         w0, r0, o0, n;
    i_rst_n     = 1'b0;
    i_reg_wr    = 1'b0;
    i_reg_rd    = 1'b0;
    i_reg_addr  = 8'h00;
    i_reg_wdata = 8'h00;
    i_pix_valid = 1'b0;
    i_pix_y     = 10'h155;
    i_pix_c     = 10'h2aa;
    err_count   = 0;
    n_checks    = 0;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    // register port: reset value, write back, unmapped address
    rd(8'h16, d);
    chk("sync_start_rst", d, 8'h80);
    wr(8'h16, 8'h70);
    rd(8'h16, d);
    chk("sync_start_rw", d, 8'h70);
    rd(8'h00, d);
    chk("unmapped_read", d, 8'h00);
    $display("test registers done");
    // line length for every standard in 20-bit format
    for (int s = 0; s < 4; s++) begin
      wr(8'h1e, {2'b00, s[1:0], 4'h0});
      wait_fall(0, 2);
      chk("line_total", tot, 2 * tot_px[s]);
      chk("line_active", act, 2 * act_px[s]);
    end
    $display("test line timing done");
    // every output format; the stream formats raise the flag early
    for (int f = 0; f < 6; f++) begin
      wr(8'h1e, 8'(f));
      wait_fall(0, 2);
      chk("active_fmt", act, 32'h5a0 + (f > 3 ? 4 : 0));
    end
    $display("test formats done");
    // sync start moves the sync pulse, 16 pixels is 32 cycles
    wr(8'h1e, 8'h00);
    wr(8'h16, 8'h80);
    wait_fall(0, 2);
    o0 = ofs;
    wr(8'h16, 8'h70);
    wait_fall(0, 2);
    chk("sync_shift", o0 - ofs, 32'h20);
    $display("test sync position done");
    // genlock word with bit 0 written as one, then a phase reset
    wr(8'h1b, 8'hab);
    wr(8'h1c, 8'haa);
    wr(8'h1d, 8'h2a);
    wait_fall(0, 1);
    w0 = words;
    r0 = rsts;
    wait_fall(0, 3);
    chk("words_per_line", words - w0, 32'h3);
    chk("no_reset_bit", rsts - r0, 32'h0);
    wr(8'h1a, 8'h10);
    wait_fall(0, 3);
    chk("reset_bit", rsts - r0, 32'h1);
    chk("words_with_reset", words - w0, 32'h6);
    $display("test genlock done");
    // buffer fills to eight in blanking, then drains in active video
    wait_fall(1, 1);
    @(posedge i_clk_sys);
    i_pix_valid <= 1'b1;
    n = 0;
    repeat (16) begin
      @(negedge i_clk_sys);
      if (o_pix_ready)
        n++;
    end
    chk("fifo_ready_full", o_pix_ready, 1'b0);
    @(posedge i_clk_sys);
    i_pix_valid <= 1'b0;
    chk("fifo_fill", n, 32'h8);
    wait_fall(0, 2);
    chk("fifo_drained", o_pix_ready, 1'b1);
    chk("y_20bit", o_y_data, 10'h155);
    chk("uv_20bit", o_uv_data, 10'h2aa);
    wr(8'h1e, 8'h01);
    repeat (2) @(negedge i_clk_sys);
    chk("y_16bit", o_y_data, 10'h154);
    chk("uv_16bit", o_uv_data, 10'h2a8);
    wr(8'h1e, 8'h02);
    repeat (2) @(negedge i_clk_sys);
    y0 = o_y_data;
    @(negedge i_clk_sys);
    chk("y_interleave", y0 ^ o_y_data, 10'h3ff);
    chk("uv_narrow", o_uv_data, 10'h000);
    $display("test buffer done");
    conclude();
  end
endmodule // tb_video_output_timing_genlock
